// ---- shared/timer_channel_pkg.sv ----
/*
  Constants and carrier types for one timer/PWM channel.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
package timer_channel_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_VALUE_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VALUE_LOW = 8'h08;

  // ----------------------------------------------------------------
  // Status/control fields
  // ----------------------------------------------------------------
  localparam int SC_FLAG = 7;
  localparam int SC_IE = 6;
  localparam int SC_MODE_B = 5;
  localparam int SC_MODE_A = 4;
  localparam int SC_EL_B = 3;
  localparam int SC_EL_A = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [1:0] EL_RELEASED = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;
  localparam logic [1:0] EL_HIGH_TRUE = 2'h2;
  localparam logic [1:0] CLOCK_NONE = 2'h0;
  localparam logic [15:0] FREE_RUN_TOP = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_COMPARE = 2'b01,
    MODE_EDGE_PWM = 2'b10,
    MODE_CENTER_PWM = 2'b11
  } mode_t;

  typedef struct packed {
    logic flag;
    logic irq_enable;
    logic channel_mode_bit_b;
    logic channel_mode_bit_a;
    logic [1:0] edge_level;
  } status_control_t;

  // Shared counter state seen by every channel
  typedef struct packed {
    logic [15:0] counter;
    logic [15:0] modulo;
    logic [1:0] clock_source;
    logic center_pwm_select;
    logic background_debug;
  } timer_shared_t;

endpackage

// ---- design/timer_channel.sv ----
/*
  One timer/PWM channel: mode decode, pin control, capture/compare flag,
  16-bit value register with byte coherency, AXI4-Lite register slave.
  Assumes the shared counter, its clock selection and modulo come from
  logic on the same clock; the channel pin comes from outside.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Mode bit A picks capture or compare
// - Edge/level 00 releases the pin
// - Capture edge: rising, falling or both
// - Compare match: none, toggle, clear, set
// - Edge PWM high-true or low-true pulses
// - Center PWM high-true or low-true pulses
// - Reset clears both value bytes
// - Capture reads latch both bytes coherently
// - Status/control write unlatches read buffer
// - Value writes ignored in capture mode
// - Debug freezes read state, reads live
// - Value bytes buffered until both written
// - No clock: transfer on second byte
// - Compare: transfer on next counter change
// - PWM: transfer on modulo-1 to modulo
// - Status/control write resets write buffer
// - Debug writes go straight to register
// - Debug writes spare pending buffered sequence
// - Flag on edge or match, not 0%/100%
// - Clock source zero stops the counter
// - Center select makes counter count up/down
module timer_channel
  import timer_channel_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AXI4-Lite write channels
  input wire logic [timer_channel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [timer_channel_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared counter state
  input wire timer_channel_pkg::timer_shared_t shared,
  // Channel pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  // Status to the rest of the timer
  output logic channel_event_flag,
  output logic channel_irq_enable
);
  import timer_channel_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  status_control_t sc_r;
  logic flag_armed_r;
  logic [15:0] value_r;
  logic [7:0] wbuf_hi_r, wbuf_lo_r;
  logic hi_seen_r, lo_seen_r, pending_r;
  logic [15:0] rbuf_r;
  logic rd_latched_r, rd_first_hi_r;
  logic pin_s1_r, pin_s2_r, pin_d_r;
  logic [15:0] cnt_prev_r;
  logic aw_held_r, w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic pin_out_r, pin_oe_n_r;

  mode_t mode;
  logic dbg, is_cap, is_pwm, clk_none;
  logic wr_do, wr_en, wr_sc, wr_vh, wr_vl;
  logic rd_do, rd_vh, rd_vl, rd_hit;
  logic cnt_moved, edge_evt, match_evt, duty_extreme;
  logic buffered_ok, second_byte, xfer_now, below;
  logic [15:0] mod_eff, immediate_val;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    if (shared.center_pwm_select) begin
      mode = MODE_CENTER_PWM;
    end else if (sc_r.channel_mode_bit_b) begin
      mode = MODE_EDGE_PWM;
    end else if (sc_r.channel_mode_bit_a) begin
      mode = MODE_COMPARE;
    end else begin
      mode = MODE_CAPTURE;
    end
  end

  assign dbg = shared.background_debug;
  assign is_cap = (mode == MODE_CAPTURE);
  assign is_pwm = (mode == MODE_EDGE_PWM) || (mode == MODE_CENTER_PWM);
  assign clk_none = (shared.clock_source == CLOCK_NONE);
  // Zero modulo means a free-running counter
  assign mod_eff = (shared.modulo == 16'h0000) ? FREE_RUN_TOP : shared.modulo;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // pin_d_r follows the pin in every mode, so a mode change alone cannot look like an edge
  always_comb begin
    edge_evt = 1'b0;
    if (is_cap) begin
      unique case (sc_r.edge_level)
        2'h1: edge_evt = pin_s2_r && !pin_d_r;
        2'h2: edge_evt = !pin_s2_r && pin_d_r;
        2'h3: edge_evt = pin_s2_r != pin_d_r;
        2'h0: edge_evt = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter watch and match
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_prev_r <= 16'h0000;
    end else begin
      cnt_prev_r <= shared.counter;
    end
  end

  assign cnt_moved = (shared.counter != cnt_prev_r);
  assign match_evt = !is_cap && cnt_moved && (shared.counter == value_r);
  assign duty_extreme = (value_r == 16'h0000) || (value_r > mod_eff);
  assign below = (shared.counter < value_r);

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign wr_do = aw_held_r && w_held_r && !bvalid_r;
  assign wr_en = wr_do && w_lane0_r;
  assign wr_sc = wr_en && (aw_addr_r == OFS_STATUS_CONTROL);
  assign wr_vh = wr_en && (aw_addr_r == OFS_VALUE_HIGH);
  assign wr_vl = wr_en && (aw_addr_r == OFS_VALUE_LOW);
  assign rd_do = s_axi_arvalid && arready_r;
  assign rd_vh = rd_do && (s_axi_araddr == OFS_VALUE_HIGH);
  assign rd_vl = rd_do && (s_axi_araddr == OFS_VALUE_LOW);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      awready_r <= 1'b1;
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_do) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r == OFS_STATUS_CONTROL || aw_addr_r == OFS_VALUE_HIGH ||
                    aw_addr_r == OFS_VALUE_LOW) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFS_STATUS_CONTROL) begin
      rd_byte = {sc_r, 2'b00};
    end else if (s_axi_araddr == OFS_VALUE_HIGH) begin
      rd_byte = (rd_latched_r && !dbg) ? rbuf_r[15:8] : value_r[15:8];
    end else if (s_axi_araddr == OFS_VALUE_LOW) begin
      rd_byte = (rd_latched_r && !dbg) ? rbuf_r[7:0] : value_r[7:0];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (rd_do) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status/control register and channel flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sc_r <= '0;
      flag_armed_r <= 1'b0;
    end else begin
      if (wr_sc) begin
        sc_r.irq_enable <= w_data_r[SC_IE];
        sc_r.channel_mode_bit_b <= w_data_r[SC_MODE_B];
        sc_r.channel_mode_bit_a <= w_data_r[SC_MODE_A];
        sc_r.edge_level <= w_data_r[SC_EL_B:SC_EL_A];
        flag_armed_r <= 1'b0;
        if (flag_armed_r && !w_data_r[SC_FLAG]) begin
          sc_r.flag <= 1'b0;
        end
      end else if (rd_do && s_axi_araddr == OFS_STATUS_CONTROL && sc_r.flag) begin
        flag_armed_r <= 1'b1;
      end
      // New event beats a clear in the same cycle
      if (edge_evt || (match_evt && !(is_pwm && duty_extreme))) begin
        sc_r.flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read coherency
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_latched_r <= 1'b0;
      rd_first_hi_r <= 1'b0;
      rbuf_r <= VALUE_RESET;
    end else if (wr_sc) begin
      rd_latched_r <= 1'b0;
    end else if ((rd_vh || rd_vl) && is_cap && !dbg) begin
      if (!rd_latched_r) begin
        rd_latched_r <= 1'b1;
        rd_first_hi_r <= rd_vh;
        rbuf_r <= value_r;
      end else if (rd_vh != rd_first_hi_r) begin
        rd_latched_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write coherency and value register
  // ----------------------------------------------------------------
  assign buffered_ok = !dbg && !is_cap;
  assign second_byte = buffered_ok && ((wr_vh && lo_seen_r) || (wr_vl && hi_seen_r));
  assign immediate_val = {wr_vh ? w_data_r : wbuf_hi_r, wr_vl ? w_data_r : wbuf_lo_r};

  // Pending transfers wait while debug holds the counter frozen
  always_comb begin
    xfer_now = 1'b0;
    if (pending_r && !dbg && !is_cap) begin
      if (clk_none) begin
        xfer_now = 1'b1;
      end else if (mode == MODE_COMPARE) begin
        xfer_now = cnt_moved;
      end else begin
        xfer_now = (cnt_prev_r == mod_eff - 16'h0001) && (shared.counter == mod_eff);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wbuf_hi_r <= 8'h00;
      wbuf_lo_r <= 8'h00;
      hi_seen_r <= 1'b0;
      lo_seen_r <= 1'b0;
      pending_r <= 1'b0;
    end else if (wr_sc) begin
      hi_seen_r <= 1'b0;
      lo_seen_r <= 1'b0;
      pending_r <= 1'b0;
    end else begin
      if (buffered_ok && wr_vh) begin
        wbuf_hi_r <= w_data_r;
        hi_seen_r <= !lo_seen_r;
      end
      if (buffered_ok && wr_vl) begin
        wbuf_lo_r <= w_data_r;
        lo_seen_r <= !hi_seen_r;
      end
      if (second_byte) begin
        lo_seen_r <= 1'b0;
        hi_seen_r <= 1'b0;
        pending_r <= !clk_none;
      end else if (xfer_now) begin
        pending_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value_r <= VALUE_RESET;
    end else if (edge_evt) begin
      value_r <= shared.counter;
    end else if (dbg && !is_cap && (wr_vh || wr_vl)) begin
      // Direct writes leave the seen/pending state alone
      if (wr_vh) begin
        value_r[15:8] <= w_data_r;
      end
      if (wr_vl) begin
        value_r[7:0] <= w_data_r;
      end
    end else if (second_byte && clk_none) begin
      value_r <= immediate_val;
    end else if (xfer_now) begin
      value_r <= {wbuf_hi_r, wbuf_lo_r};
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else begin
      pin_oe_n_r <= is_cap || (sc_r.edge_level == EL_RELEASED);
      unique case (mode)
        MODE_COMPARE: begin
          if (match_evt) begin
            unique case (sc_r.edge_level)
              EL_TOGGLE: pin_out_r <= !pin_out_r;
              EL_CLEAR: pin_out_r <= 1'b0;
              EL_SET: pin_out_r <= 1'b1;
              EL_RELEASED: pin_out_r <= pin_out_r;
            endcase
          end
        end
        // Level from counter versus value covers both alignments
        MODE_EDGE_PWM, MODE_CENTER_PWM: begin
          pin_out_r <= (sc_r.edge_level == EL_HIGH_TRUE) ? below : !below;
        end
        MODE_CAPTURE: pin_out_r <= pin_out_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign channel_event_flag = sc_r.flag;
  assign channel_irq_enable = sc_r.irq_enable;

endmodule

`default_nettype wire

// ---- testbench/timer_channel_props.sv ----
/*
  Checker for one timer channel: pin drive and capture flag per mode.
  Assumes the master offers write address and data in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_channel_props
  import timer_channel_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Write channels
  input wire logic [timer_channel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Timer and pin
  input wire timer_channel_pkg::timer_shared_t shared,
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic channel_event_flag
);
  import timer_channel_pkg::*;

  logic [3:0] sc_r;
  logic [4:0] cfg;

  // Shadow of mode and edge bits; design applies them one edge later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sc_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == OFS_STATUS_CONTROL && s_axi_wstrb[0]) begin
      sc_r <= s_axi_wdata[5:2];
    end
  end
  assign cfg = {shared.center_pwm_select, sc_r};

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_pin_released: assert property (
    (sc_r[1:0] == 2'h0) [*4] |-> pin_oe_n)
    else $error("pin driven while released");
  chk_capture_no_drive: assert property (
    (cfg[4:2] == 3'h0) [*4] |-> pin_oe_n)
    else $error("pin driven in capture mode");
  chk_rise_captured: assert property (
    (cfg == 5'h01) [*4] ##0 $rose(pin_in) |-> ##[1:5] channel_event_flag)
    else $error("rising edge not captured");
  chk_fall_captured: assert property (
    (cfg == 5'h03) [*4] ##0 $fell(pin_in) |-> ##[1:5] channel_event_flag)
    else $error("falling edge not captured");
  chk_compare_drive: assert property (
    (cfg[4:2] == 3'h1 && sc_r[1:0] != 2'h0) [*4] |-> !pin_oe_n)
    else $error("compare pin not driven");
  chk_set_no_fall: assert property (
    (cfg == 5'h07) [*4] |-> !$fell(pin_out))
    else $error("pin fell in set mode");
  chk_clear_no_rise: assert property (
    (cfg == 5'h06) [*4] |-> !$rose(pin_out))
    else $error("pin rose in clear mode");
  chk_toggle_on_match: assert property (
    (cfg == 5'h05) [*4] ##0 $changed(pin_out) |-> ##[0:1] channel_event_flag)
    else $error("toggle without match flag");
  chk_pwm_drive: assert property (
    ((sc_r[3] || cfg[4]) && sc_r[1:0] != 2'h0) [*4] |-> !pin_oe_n)
    else $error("pwm pin not driven");
endmodule

bind timer_channel timer_channel_props i_timer_channel_props (
  .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .shared, .pin_in, .pin_out, .pin_oe_n,
  .channel_event_flag);
`default_nettype wire

// ---- testbench/pin_source.sv ----
/*
  External source on the channel pin.
  Assumes the bench requests levels; the design side wins while it drives.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock
  input wire logic clock,
  // Requested level and design side
  input wire logic level,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Resolved pin
  output logic pin_in
);
  logic drv_r;

  // Changes only at edges; bench keeps it still before capture is chosen
  always_ff @(posedge clock) begin
    drv_r <= level;
  end
  assign pin_in = pin_oe_n ? drv_r : pin_out;
endmodule
`default_nettype wire

// ---- testbench/tb_timer_channel.sv ----
/*
  Self-checking bench for one timer channel over AXI4-Lite.
  Assumes the checker is bound and the pin source stands on the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel;
  import timer_channel_pkg::*;
  localparam logic [7:0] SC = OFS_STATUS_CONTROL;
  localparam logic [7:0] VH = OFS_VALUE_HIGH;
  localparam logic [7:0] VL = OFS_VALUE_LOW;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  timer_shared_t shared = '0;
  logic level = 1'h0;
  logic pin_in, pin_out, pin_oe_n, channel_event_flag, channel_irq_enable;
  int failures = 0;
  int n_checks = 0;

  always #4 clock = ~clock;

  timer_channel i_timer_channel (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .shared, .pin_in, .pin_out, .pin_oe_n, .channel_event_flag, .channel_irq_enable);
  pin_source i_pin_source (.clock, .level, .pin_out, .pin_oe_n, .pin_in);

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n > 60) begin
      failures++;
      test_done();
    end
  endtask

  // Entry edge first, so a strobe lowered by the last call never meets its raise
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      guard(n);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    ck(32'(s_axi_bresp), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      guard(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    ck(s_axi_rdata, {24'h0, e});
    ck(32'(s_axi_rresp), 32'(r));
  endtask

  task automatic cnt(input logic [15:0] v);
    @(posedge clock);
    shared.counter <= v;
    repeat (3) @(posedge clock);
  endtask

  task automatic pin(input logic v);
    @(posedge clock);
    level <= v;
    repeat (6) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(VH, 8'h00);
    rd(VL, 8'h00);
    rd(8'h0c, 8'h00, RESP_SLVERR);
    wr(8'h0c, 8'hff, RESP_SLVERR);
  endtask

  task automatic t_capture();
    cnt(16'h1234);
    wr(SC, 8'h04);
    pin(1'h1);
    rd(SC, 8'h84);
    rd(VH, 8'h12);
    cnt(16'h5678);
    pin(1'h0);
    cnt(16'h9abc);
    pin(1'h1);
    rd(VL, 8'h34);
    rd(VL, 8'hbc);
    wr(VL, 8'h00);
    rd(VH, 8'h9a);
    rd(VL, 8'hbc);
    wr(SC, 8'h08);
    cnt(16'h3333);
    pin(1'h0);
    cnt(16'h4444);
    pin(1'h1);
    rd(VL, 8'h33);
    cnt(16'h1111);
    wr(SC, 8'h0c);
    pin(1'h0);
    rd(VH, 8'h11);
    rd(SC, 8'h8c);
  endtask

  task automatic t_debug_read();
    cnt(16'h2222);
    shared.background_debug <= 1'h1;
    pin(1'h1);
    rd(VL, 8'h22);
    rd(VH, 8'h22);
    shared.background_debug <= 1'h0;
    rd(VL, 8'h11);
  endtask

  task automatic t_write_pair();
    wr(SC, 8'h10);
    rd(SC, 8'h10);
    wr(VH, 8'ha5);
    rd(VH, 8'h22);
    wr(VL, 8'h5a);
    rd(VH, 8'ha5);
    rd(VL, 8'h5a);
    s_axi_wstrb <= 4'h0;
    wr(VH, 8'hee);
    wr(VL, 8'hee);
    s_axi_wstrb <= 4'h1;
    rd(VL, 8'h5a);
    wr(VL, 8'h01);
    wr(SC, 8'h50);
    ck(32'(channel_irq_enable), 32'h1);
    wr(VH, 8'h02);
    rd(VH, 8'ha5);
    wr(VL, 8'h03);
    rd(VH, 8'h02);
  endtask

  task automatic t_debug_write();
    wr(VH, 8'h77);
    shared.background_debug <= 1'h1;
    wr(VL, 8'h99);
    rd(VL, 8'h99);
    rd(VH, 8'h02);
    shared.background_debug <= 1'h0;
    wr(VL, 8'h44);
    rd(VH, 8'h77);
  endtask

  task automatic t_transfer();
    shared.clock_source <= 2'h1;
    wr(VH, 8'h00);
    wr(VL, 8'h10);
    rd(VL, 8'h44);
    cnt(16'h2223);
    rd(VL, 8'h10);
  endtask

  task automatic t_compare_pin();
    logic [7:0] m[4] = '{8'h1c, 8'h18, 8'h14, 8'h14};
    for (int i = 0; i < 4; i++) begin
      wr(SC, m[i]);
      cnt(16'h000f);
      cnt(16'h0010);
      ck(32'(pin_out), 32'(!i[0]));
      ck(32'(pin_oe_n), 32'h0);
    end
    wr(SC, 8'h10);
    repeat (2) @(posedge clock);
    ck(32'(pin_oe_n), 32'h1);
    rd(SC, 8'h90);
  endtask

  task automatic t_pwm();
    shared.modulo <= 16'h0020;
    wr(SC, 8'h28);
    wr(VH, 8'h00);
    wr(VL, 8'h08);
    cnt(16'h001f);
    rd(VL, 8'h10);
    cnt(16'h0020);
    rd(VL, 8'h08);
    cnt(16'h0003);
    ck(32'(pin_out), 32'h1);
    cnt(16'h000a);
    ck(32'(pin_out), 32'h0);
    wr(SC, 8'h24);
    repeat (2) @(posedge clock);
    ck(32'(pin_out), 32'h1);
    shared.center_pwm_select <= 1'h1;
    wr(SC, 8'h08);
    cnt(16'h0003);
    ck(32'(pin_out), 32'h1);
    ck(32'(pin_oe_n), 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    t_reset();
    t_capture();
    t_debug_read();
    t_write_pair();
    t_debug_write();
    t_transfer();
    t_compare_pin();
    t_pwm();
    test_done();
  end
endmodule
`default_nettype wire
